// File: csm_map.svh
// Register offsets, field positions and reset values of the clock source manager
`ifndef CSM_MAP_SVH
`define CSM_MAP_SVH
// Register offsets
`define CSM_OFF_CTRL1 8'h00
`define CSM_OFF_CFG1 8'h04
`define CSM_OFF_INT 8'h08
`define CSM_OFF_RTC 8'h20
`define CSM_OFF_CSTS 8'h24
`define CSM_OFF_CTRL2 8'h34
// clock_control_reg_one fields
`define CSM_B_FAST_INT_OSC_ENABLE 0
`define CSM_B_HSIRDY 1
`define CSM_B_FAST_INT_TRIM 3
`define CSM_B_HSICAL 8
`define CSM_B_FAST_EXT_OSC_ENABLE 16
`define CSM_B_HSERDY 17
`define CSM_B_HSEBYP 18
`define CSM_B_CLOCK_FAILURE_MONITOR_ENABLE 19
`define CSM_B_PLL_ON_BIT 24
`define CSM_B_PLLRDY 25
// clock_config_reg_one fields
`define CSM_B_SW 0
`define CSM_B_SWS 2
`define CSM_B_APBPRE 8
`define CSM_B_PLLSRC 16
`define CSM_B_PLLMUL 18
`define CSM_B_CLOCK_OUTPUT_SELECT 24
// clock_interrupt_reg fields
`define CSM_B_FLAG 0
`define CSM_B_CSSF 7
`define CSM_B_IEN 8
`define CSM_B_CLR 16
`define CSM_B_CLOCK_FAILURE_CLEAR 23
// rtc_domain_control_reg fields
`define CSM_B_SLOW_EXT_OSC_ENABLE 0
`define CSM_B_LSERDY 1
`define CSM_B_LSEBYP 2
`define CSM_B_RTCSEL 8
`define CSM_B_RTCRST 16
// control_status_reg fields
`define CSM_B_SLOW_INT_OSC_ENABLE 0
`define CSM_B_LSIRDY 1
// clock_control_reg_two fields
`define CSM_B_ADCEN 0
`define CSM_B_ADCRDY 1
`define CSM_B_ADCTRM 3
// Ready and flag indices
`define CSM_I_LSI 0
`define CSM_I_LSE 1
`define CSM_I_HSI 2
`define CSM_I_HSE 3
`define CSM_I_PLL 4
`define CSM_I_ADC 5
`define CSM_I_FAIL 6
// Reset values
`define CSM_TRIM_RST 5'h10
`define CSM_ADC_TRIM_RST 5'h10
`endif

// File: csm_pkg.sv
// Types shared by the clock source manager
`default_nettype none
package csm_pkg;
  typedef enum logic [1:0] {CSM_SRC_HSI = 2'b00, CSM_SRC_HSE = 2'b01, CSM_SRC_PLL = 2'b10} csm_src_t;
  typedef enum logic [1:0] {CSM_LP_RUN = 2'b00, CSM_LP_SLEEP = 2'b01, CSM_LP_STOP = 2'b10,
    CSM_LP_STANDBY = 2'b11} csm_mode_t;
  typedef enum logic [1:0] {CSM_PS_RUN = 2'b00, CSM_PS_WAIT = 2'b01, CSM_PS_DEEP = 2'b10} csm_pwr_t;
  // Controls to the analog oscillators and the clock tree
  typedef struct packed {
    logic hse_en; logic hse_byp; logic lse_en; logic lse_byp;
    logic hsi_en; logic adc_osc_en; logic lsi_en; logic pll_en;
    logic pll_src; logic [3:0] pll_mul;
    logic [4:0] hsi_trim; logic [7:0] hsi_cal; logic [4:0] adc_osc_trim;
    csm_src_t sys_src; logic [5:0] gate; logic [1:0] rtc_sel; logic wdt_clk_en;
    logic [2:0] mco_sel; logic tmr_double; logic adc_osc_route;
    logic cpu_clk_en; logic bridge_clk_en; logic deep_sleep; logic irq; logic nmi;
  } csm_out_t;
  // Whole state of the manager
  typedef struct packed {
    logic [6:0] sync1; logic [6:0] sync2; logic [6:0] prev;
    logic [5:0] flags; logic [5:0] irq_en; logic css_pend;
    logic fast_int_osc_enable; logic fast_ext_osc_enable; logic hsebyp; logic clock_failure_monitor_enable; logic pll_on_bit; logic pllsrc; logic [3:0] pllmul;
    logic [4:0] trim; logic [7:0] cal; logic cal_done;
    csm_src_t sw; csm_src_t sws; logic [2:0] apbpre; logic [2:0] clock_output_select;
    logic slow_ext_osc_enable; logic lsebyp; logic [1:0] rtcsel; logic slow_int_osc_enable; logic wdt_lock;
    logic adcen; logic [4:0] adctrim; csm_pwr_t pwr; logic [31:0] rdata; csm_out_t out;
  } csm_state_t;
endpackage
`default_nettype wire

// File: csm_clock_source_manager.sv
// Clock source manager: oscillator control, system clock switch, failure monitor, low power
//
// How it works
// - slow bypass needs bypass and enable bits
// - slow external ready flag, interrupt when enabled
// - factory calibration loaded after reset release, trim adjustable
// - fast internal enable bit, ready-gated output
// - converter oscillator enable, trim, ready gating
// - slow internal enable, ready gating, runs low-power
// - PLL source and multiplier frozen while enabled
// - PLL ready raises interrupt when enabled
// - timer clock doubles unless prescaler is one
// - RTC source written once until domain reset
// - watchdog forces slow internal oscillator permanently on
// - clock output select reaches pin when configured
// - system clock from three sources, reset internal
// - switch only to ready source, in-use stays on
// - external failure falls back to internal oscillator
// - failure pending drives NMI until software clears
// - converter clock from oscillator or bus clock
// - sleep stops processor, bridge stops when all bus peripheral clocks are off
// - stop or standby turns fast oscillators off
// - wake-up selects fast internal oscillator
// - deep sleep waits for flash and bus
// - deep sleep entry clears fast external enable
// - fast internal enable set by hardware events
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "csm_map.svh"
`default_nettype none
module csm_clock_source_manager (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [31:0] o_rdata,
  // Oscillator status pins, asynchronous
  input wire logic [5:0] i_osc_ready,
  input wire logic i_hse_fail,
  // Factory calibration word, static
  input wire logic [7:0] i_hsi_cal,
  // Same-clock system inputs
  input wire logic i_wdt_enable,
  input wire csm_pkg::csm_mode_t i_lp_mode,
  input wire logic i_wake,
  input wire logic i_flash_busy,
  input wire logic i_apb_busy,
  input wire logic i_apb_clks_off,
  input wire logic i_mco_af,
  input wire logic i_adc_sel_osc,
  // Clock tree controls
  output csm_pkg::csm_out_t o_ctl
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  csm_pkg::csm_state_t s_q; // Registered state
  csm_pkg::csm_state_t s_d; // Next state
  logic [5:0] rdy; // Synchronized ready levels
  logic [5:0] rise; // Ready rising edges
  logic hse_used; // External oscillator feeds system clock
  logic hsi_used; // Internal oscillator feeds system clock
  logic css_evt; // Failure takes effect this cycle
  logic tgt_ok; // Switch target enabled and ready
  logic [5:0] clr; // Flag clear mask from software
  logic css_clr; // Failure pending clear
  logic deep; // Next state is deep sleep

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // All decisions use the second synchronizer stage only
  always_comb
  begin
    s_d = s_q;
    s_d.sync1 = {i_hse_fail, i_osc_ready};
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    rdy = s_q.sync2[5:0];
    rise = rdy & ~s_q.prev[5:0];
    hse_used = (s_q.sws == csm_pkg::CSM_SRC_HSE) || ((s_q.sws == csm_pkg::CSM_SRC_PLL) && s_q.pllsrc);
    hsi_used = (s_q.sws == csm_pkg::CSM_SRC_HSI) || ((s_q.sws == csm_pkg::CSM_SRC_PLL) && !s_q.pllsrc);
    css_evt = s_q.clock_failure_monitor_enable && s_q.sync2[`CSM_I_FAIL] && hse_used && s_q.fast_ext_osc_enable;
    clr = 6'h00;
    css_clr = 1'b0;
    // Calibration word is caught after reset release, never under reset
    if (!s_q.cal_done)
    begin
      s_d.cal = i_hsi_cal;
      s_d.cal_done = 1'b1;
    end
    // Register writes
    if (i_we)
    begin
      if (i_addr == `CSM_OFF_CTRL1)
      begin
        s_d.fast_int_osc_enable = i_wdata[`CSM_B_FAST_INT_OSC_ENABLE] | hsi_used;
        s_d.trim = i_wdata[`CSM_B_FAST_INT_TRIM +: 5];
        s_d.fast_ext_osc_enable = i_wdata[`CSM_B_FAST_EXT_OSC_ENABLE] | hse_used;
        s_d.hsebyp = i_wdata[`CSM_B_HSEBYP];
        s_d.clock_failure_monitor_enable = i_wdata[`CSM_B_CLOCK_FAILURE_MONITOR_ENABLE];
        s_d.pll_on_bit = i_wdata[`CSM_B_PLL_ON_BIT] | (s_q.sws == csm_pkg::CSM_SRC_PLL);
      end
      else if (i_addr == `CSM_OFF_CFG1)
      begin
        // Code 2'b11 is no source and leaves the request alone
        if (i_wdata[`CSM_B_SW +: 2] != 2'b11)
        begin
          s_d.sw = csm_pkg::csm_src_t'(i_wdata[`CSM_B_SW +: 2]);
        end
        s_d.apbpre = i_wdata[`CSM_B_APBPRE +: 3];
        s_d.clock_output_select = i_wdata[`CSM_B_CLOCK_OUTPUT_SELECT +: 3];
        // PLL setup only while fully stopped
        if (!s_q.pll_on_bit && !rdy[`CSM_I_PLL])
        begin
          s_d.pllsrc = i_wdata[`CSM_B_PLLSRC];
          s_d.pllmul = i_wdata[`CSM_B_PLLMUL +: 4];
        end
      end
      else if (i_addr == `CSM_OFF_INT)
      begin
        s_d.irq_en = i_wdata[`CSM_B_IEN +: 6];
        clr = i_wdata[`CSM_B_CLR +: 6];
        css_clr = i_wdata[`CSM_B_CLOCK_FAILURE_CLEAR];
      end
      else if (i_addr == `CSM_OFF_RTC)
      begin
        s_d.slow_ext_osc_enable = i_wdata[`CSM_B_SLOW_EXT_OSC_ENABLE];
        s_d.lsebyp = i_wdata[`CSM_B_LSEBYP];
        // Domain reset frees the source; otherwise only the first pick sticks
        if (i_wdata[`CSM_B_RTCRST])
        begin
          s_d.rtcsel = 2'h0;
        end
        else if (s_q.rtcsel == 2'h0)
        begin
          s_d.rtcsel = i_wdata[`CSM_B_RTCSEL +: 2];
        end
      end
      else if (i_addr == `CSM_OFF_CSTS)
      begin
        s_d.slow_int_osc_enable = i_wdata[`CSM_B_SLOW_INT_OSC_ENABLE];
      end
      else if (i_addr == `CSM_OFF_CTRL2)
      begin
        s_d.adcen = i_wdata[`CSM_B_ADCEN];
        s_d.adctrim = i_wdata[`CSM_B_ADCTRM +: 5];
      end
    end
    // Sticky flags: a new edge wins over a clear in the same cycle
    s_d.flags = (s_q.flags & ~clr) | rise;
    s_d.css_pend = (s_q.css_pend & ~css_clr) | css_evt;
    // Switch waits for the target to be on and stable
    case (s_q.sw)
      csm_pkg::CSM_SRC_HSE: tgt_ok = s_q.fast_ext_osc_enable && rdy[`CSM_I_HSE];
      csm_pkg::CSM_SRC_PLL: tgt_ok = s_q.pll_on_bit && rdy[`CSM_I_PLL];
      default: tgt_ok = s_q.fast_int_osc_enable && rdy[`CSM_I_HSI];
    endcase
    if (tgt_ok)
    begin
      s_d.sws = s_q.sw;
    end
    // Failure overrides software and the switch
    if (css_evt)
    begin
      s_d.fast_ext_osc_enable = 1'b0;
      if (s_q.pllsrc)
      begin
        s_d.pll_on_bit = 1'b0;
      end
      s_d.sw = csm_pkg::CSM_SRC_HSI;
      s_d.sws = csm_pkg::CSM_SRC_HSI;
      s_d.fast_int_osc_enable = 1'b1;
    end
    // Watchdog lock can never be released short of reset
    if (i_wdt_enable)
    begin
      s_d.wdt_lock = 1'b1;
    end
    // Low-power sequencing
    case (s_q.pwr)
      csm_pkg::CSM_PS_RUN:
      begin
        if ((i_lp_mode == csm_pkg::CSM_LP_STOP) || (i_lp_mode == csm_pkg::CSM_LP_STANDBY))
        begin
          s_d.pwr = csm_pkg::CSM_PS_WAIT;
        end
      end
      csm_pkg::CSM_PS_WAIT:
      begin
        // Request withdrawn before entry aborts it
        if ((i_lp_mode == csm_pkg::CSM_LP_RUN) || (i_lp_mode == csm_pkg::CSM_LP_SLEEP))
        begin
          s_d.pwr = csm_pkg::CSM_PS_RUN;
        end
        else if (!i_flash_busy && !i_apb_busy)
        begin
          s_d.pwr = csm_pkg::CSM_PS_DEEP;
          s_d.fast_ext_osc_enable = 1'b0;
          s_d.pll_on_bit = 1'b0;
        end
      end
      csm_pkg::CSM_PS_DEEP:
      begin
        if (i_wake)
        begin
          s_d.pwr = csm_pkg::CSM_PS_RUN;
          s_d.fast_int_osc_enable = 1'b1;
          s_d.sw = csm_pkg::CSM_SRC_HSI;
          s_d.sws = csm_pkg::CSM_SRC_HSI;
        end
      end
      default: s_d.pwr = csm_pkg::CSM_PS_RUN;
    endcase
    deep = (s_d.pwr == csm_pkg::CSM_PS_DEEP);
    // Outputs, registered with the state
    s_d.out.hse_en = s_d.fast_ext_osc_enable && !deep;
    s_d.out.hse_byp = s_d.hsebyp;
    s_d.out.lse_en = s_d.slow_ext_osc_enable;
    s_d.out.lse_byp = s_d.lsebyp && s_d.slow_ext_osc_enable;
    s_d.out.hsi_en = s_d.fast_int_osc_enable && !deep;
    s_d.out.adc_osc_en = s_d.adcen && !deep;
    s_d.out.lsi_en = s_d.slow_int_osc_enable || s_d.wdt_lock;
    s_d.out.pll_en = s_d.pll_on_bit && !deep;
    s_d.out.pll_src = s_d.pllsrc;
    s_d.out.pll_mul = s_d.pllmul;
    s_d.out.hsi_trim = s_d.trim;
    s_d.out.hsi_cal = s_d.cal;
    s_d.out.adc_osc_trim = s_d.adctrim;
    s_d.out.sys_src = s_d.sws;
    // Each clock is released only while its ready level is high
    s_d.out.gate = rdy & {s_d.out.adc_osc_en, s_d.out.pll_en, s_d.out.hse_en, s_d.out.hsi_en,
      s_d.out.lse_en, s_d.out.lsi_en};
    s_d.out.rtc_sel = s_d.rtcsel;
    s_d.out.wdt_clk_en = s_d.wdt_lock && rdy[`CSM_I_LSI];
    s_d.out.mco_sel = i_mco_af ? s_d.clock_output_select : 3'h0;
    s_d.out.tmr_double = (s_d.apbpre != 3'h0);
    s_d.out.adc_osc_route = i_adc_sel_osc && s_d.out.gate[`CSM_I_ADC];
    s_d.out.cpu_clk_en = (i_lp_mode == csm_pkg::CSM_LP_RUN) && !deep;
    s_d.out.bridge_clk_en = !((i_lp_mode == csm_pkg::CSM_LP_SLEEP) && i_apb_clks_off) && !deep;
    s_d.out.deep_sleep = deep;
    s_d.out.irq = |(s_d.flags & s_d.irq_en);
    s_d.out.nmi = s_d.css_pend;
    // Read data stands one cycle only
    s_d.rdata = 32'h0000_0000;
    if (i_re)
    begin
      if (i_addr == `CSM_OFF_CTRL1)
      begin
        s_d.rdata[`CSM_B_FAST_INT_OSC_ENABLE] = s_q.fast_int_osc_enable;
        s_d.rdata[`CSM_B_HSIRDY] = rdy[`CSM_I_HSI];
        s_d.rdata[`CSM_B_FAST_INT_TRIM +: 5] = s_q.trim;
        s_d.rdata[`CSM_B_HSICAL +: 8] = s_q.cal;
        s_d.rdata[`CSM_B_FAST_EXT_OSC_ENABLE] = s_q.fast_ext_osc_enable;
        s_d.rdata[`CSM_B_HSERDY] = rdy[`CSM_I_HSE];
        s_d.rdata[`CSM_B_HSEBYP] = s_q.hsebyp;
        s_d.rdata[`CSM_B_CLOCK_FAILURE_MONITOR_ENABLE] = s_q.clock_failure_monitor_enable;
        s_d.rdata[`CSM_B_PLL_ON_BIT] = s_q.pll_on_bit;
        s_d.rdata[`CSM_B_PLLRDY] = rdy[`CSM_I_PLL];
      end
      else if (i_addr == `CSM_OFF_CFG1)
      begin
        s_d.rdata[`CSM_B_SW +: 2] = s_q.sw;
        s_d.rdata[`CSM_B_SWS +: 2] = s_q.sws;
        s_d.rdata[`CSM_B_APBPRE +: 3] = s_q.apbpre;
        s_d.rdata[`CSM_B_PLLSRC] = s_q.pllsrc;
        s_d.rdata[`CSM_B_PLLMUL +: 4] = s_q.pllmul;
        s_d.rdata[`CSM_B_CLOCK_OUTPUT_SELECT +: 3] = s_q.clock_output_select;
      end
      else if (i_addr == `CSM_OFF_INT)
      begin
        s_d.rdata[`CSM_B_FLAG +: 6] = s_q.flags;
        s_d.rdata[`CSM_B_CSSF] = s_q.css_pend;
        s_d.rdata[`CSM_B_IEN +: 6] = s_q.irq_en;
      end
      else if (i_addr == `CSM_OFF_RTC)
      begin
        s_d.rdata[`CSM_B_SLOW_EXT_OSC_ENABLE] = s_q.slow_ext_osc_enable;
        s_d.rdata[`CSM_B_LSERDY] = rdy[`CSM_I_LSE];
        s_d.rdata[`CSM_B_LSEBYP] = s_q.lsebyp;
        s_d.rdata[`CSM_B_RTCSEL +: 2] = s_q.rtcsel;
      end
      else if (i_addr == `CSM_OFF_CSTS)
      begin
        s_d.rdata[`CSM_B_SLOW_INT_OSC_ENABLE] = s_q.slow_int_osc_enable || s_q.wdt_lock;
        s_d.rdata[`CSM_B_LSIRDY] = rdy[`CSM_I_LSI];
      end
      else if (i_addr == `CSM_OFF_CTRL2)
      begin
        s_d.rdata[`CSM_B_ADCEN] = s_q.adcen;
        s_d.rdata[`CSM_B_ADCRDY] = rdy[`CSM_I_ADC];
        s_d.rdata[`CSM_B_ADCTRM +: 5] = s_q.adctrim;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset leaves only the internal oscillator running as system clock
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      s_q <= '0;
      s_q.fast_int_osc_enable <= 1'b1;
      s_q.trim <= `CSM_TRIM_RST;
      s_q.adctrim <= `CSM_ADC_TRIM_RST;
      s_q.out.hsi_en <= 1'b1;
      s_q.out.hsi_trim <= `CSM_TRIM_RST;
      s_q.out.adc_osc_trim <= `CSM_ADC_TRIM_RST;
      s_q.out.cpu_clk_en <= 1'b1;
      s_q.out.bridge_clk_en <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_ctl = s_q.out;
  assign o_rdata = s_q.rdata;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  logic hse_used_q; // Failure monitor condition seen from state
  assign hse_used_q = (s_q.sws == csm_pkg::CSM_SRC_HSE) || ((s_q.sws == csm_pkg::CSM_SRC_PLL) && s_q.pllsrc);

  a_flag_sticky_hold: assert property (
    s_q.flags[`CSM_I_PLL] && !(i_we && (i_addr == `CSM_OFF_INT)) |=> s_q.flags[`CSM_I_PLL])
    else $error("ready flag dropped without a clear");
  a_irq_and_enable: assert property (
    s_q.out.irq == |(s_q.flags & s_q.irq_en))
    else $error("interrupt request not flag AND enable");
  a_pll_ready_flag: assert property (
    $rose(s_q.sync2[`CSM_I_PLL]) |=> s_q.flags[`CSM_I_PLL])
    else $error("PLL ready edge did not set its flag");
  a_pll_cfg_frozen: assert property (
    s_q.pll_on_bit |=> $stable(s_q.pllmul) && $stable(s_q.pllsrc))
    else $error("PLL setup changed while enabled");
  a_switch_needs_ready: assert property (
    $changed(s_q.sws) && (s_q.sws == csm_pkg::CSM_SRC_PLL) |-> $past(s_q.sync2[`CSM_I_PLL]))
    else $error("switched to PLL before it was ready");
  a_css_fallback_hsi: assert property (
    s_q.clock_failure_monitor_enable && s_q.sync2[`CSM_I_FAIL] && s_q.fast_ext_osc_enable && hse_used_q
    |=> (s_q.sws == csm_pkg::CSM_SRC_HSI) && !s_q.fast_ext_osc_enable && s_q.fast_int_osc_enable && s_q.out.nmi)
    else $error("failure did not fall back to internal oscillator");
  a_nmi_held: assert property (
    s_q.css_pend && !(i_we && (i_addr == `CSM_OFF_INT) && i_wdata[`CSM_B_CLOCK_FAILURE_CLEAR]) |=> s_q.out.nmi && s_q.css_pend)
    else $error("NMI dropped without a clear");
  a_wdt_lsi_forced: assert property (
    $rose(s_q.wdt_lock) |-> s_q.out.lsi_en ##1 s_q.out.lsi_en)
    else $error("watchdog did not keep slow oscillator on");
  a_deep_deferred: assert property (
    (s_q.pwr == csm_pkg::CSM_PS_WAIT) && (i_flash_busy || i_apb_busy) |=> !s_q.out.deep_sleep)
    else $error("deep sleep entered while busy");
  a_deep_osc_off: assert property (
    s_q.out.deep_sleep |-> !s_q.out.hse_en && !s_q.out.pll_en && !s_q.out.hsi_en && !s_q.out.adc_osc_en)
    else $error("fast oscillator running in deep sleep");
  a_wake_on_hsi: assert property (
    (s_q.pwr == csm_pkg::CSM_PS_DEEP) && i_wake |=> (s_q.out.sys_src == csm_pkg::CSM_SRC_HSI) && s_q.out.hsi_en)
    else $error("wake-up did not select internal oscillator");
  a_timer_double: assert property (
    s_q.out.tmr_double == (s_q.apbpre != 3'h0))
    else $error("timer doubling wrong for prescaler");

  c_switch_pll: cover property ($changed(s_q.sws) && (s_q.sws == csm_pkg::CSM_SRC_PLL));
  c_css_event: cover property ($rose(s_q.css_pend));
  c_deep_wake: cover property (s_q.out.deep_sleep ##1 !s_q.out.deep_sleep);
  c_ready_irq: cover property ($rose(s_q.out.irq));

endmodule
`default_nettype wire

// File: csm_osc_model.sv
// Behavioural oscillators and failure pin facing the clock source manager
`timescale 1ns/1ps
`default_nettype none
module csm_osc_model (
  // Clock and controls
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic i_fail_cmd,
  input wire logic [5:0] i_en,
  // Status pins
  output logic [5:0] o_ready,
  output logic o_fail
);
  // Start-up counters, one per oscillator
  logic [4:0] cnt_q [6];
  initial
  begin
    o_ready = 6'h00;
    o_fail = 1'b0;
    for (int i = 0; i < 6; i++) cnt_q[i] = 5'h00;
  end
  // Ready rises after start-up, drops as soon as the source stops
  // A failed crystal loses its ready level too, so the far side is no kinder than a real one
  always @(posedge i_clk)
  begin
    o_fail <= i_fail_cmd;
    for (int i = 0; i < 6; i++)
    begin
      if (!i_en[i] || (i == 3 && i_fail_cmd))
      begin
        cnt_q[i] <= 5'h00;
        o_ready[i] <= 1'b0;
      end
      else if (cnt_q[i] == (i_slow ? 5'h14 : 5'h02))
        o_ready[i] <= 1'b1;
      else
        cnt_q[i] <= cnt_q[i] + 5'h01;
    end
  end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench of the clock source manager
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Table row: write, then read back under a mask
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] e;} csm_tb_row_t;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_we = 1'b0;
  logic i_re = 1'b0;
  logic [31:0] o_rdata;
  logic [5:0] ready;
  logic fail_pin;
  logic i_slow = 1'b0;
  logic fail_cmd = 1'b0;
  logic wdt = 1'b0;
  csm_pkg::csm_mode_t lp = csm_pkg::CSM_LP_RUN;
  logic wake = 1'b0;
  logic flash_busy = 1'b0;
  logic apb_busy = 1'b0;
  logic clks_off = 1'b0;
  logic mco_af = 1'b0;
  logic adc_sel = 1'b0;
  csm_pkg::csm_out_t o_ctl;
  int fail_count = 0;
  int samples_checked = 0;
  int k;
  csm_tb_row_t rows [6] = '{
    '{8'h00, 32'h0000_0049, 32'h0000_00f9, 32'h0000_0049},
    '{8'h34, 32'h0000_0059, 32'h0000_00f9, 32'h0000_0059},
    '{8'h08, 32'h0000_3f00, 32'h0000_3f00, 32'h0000_3f00},
    '{8'h20, 32'h0000_0105, 32'h0000_0305, 32'h0000_0105},
    '{8'h04, 32'h0000_0400, 32'h0000_0703, 32'h0000_0400},
    '{8'h40, 32'hffff_ffff, 32'hffff_ffff, 32'h0000_0000}};
  // 100 MHz system clock
  always #5 i_clk_sys = ~i_clk_sys;
  csm_clock_source_manager csm_clock_source_manager_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata),
    .i_osc_ready(ready), .i_hse_fail(fail_pin), .i_hsi_cal(8'h5a), .i_wdt_enable(wdt),
    .i_lp_mode(lp), .i_wake(wake), .i_flash_busy(flash_busy), .i_apb_busy(apb_busy),
    .i_apb_clks_off(clks_off), .i_mco_af(mco_af), .i_adc_sel_osc(adc_sel), .o_ctl(o_ctl));
  csm_osc_model csm_osc_model_inst (.i_clk(i_clk_sys), .i_slow(i_slow), .i_fail_cmd(fail_cmd),
    .i_en({o_ctl.adc_osc_en, o_ctl.pll_en, o_ctl.hse_en, o_ctl.hsi_en, o_ctl.lse_en, o_ctl.lsi_en}),
    .o_ready(ready), .o_fail(fail_pin));
  // Verdict and end of run
  task stop_test;
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task bad(input string m);
    $display("wrong value at %0t: %s", $time, m);
    fail_count++;
  endtask
  task cmp_rd(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    samples_checked++;
    if ((got & msk) !== exp) bad("read data");
  endtask
  task cmp_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) bad("control bit");
  endtask
  task cmp_src(input csm_pkg::csm_src_t got, input csm_pkg::csm_src_t exp);
    samples_checked++;
    if (got !== exp) bad("system clock source");
  endtask
  // A wait that used up its bound ends the run
  task bound(input int n);
    if (n >= 60)
    begin
      bad("timeout");
      stop_test();
    end
  endtask
  // Outputs are looked at 1 ns after the edge, once they have settled
  task tick;
    @(posedge i_clk_sys);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_we <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_we <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    @(posedge i_clk_sys);
    i_re <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_re <= 1'b0;
    #1;
    cmp_rd(o_rdata, exp, msk);
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    repeat (3) tick;
    cmp_bit(o_ctl.hsi_en, 1'b1);
    cmp_src(o_ctl.sys_src, csm_pkg::CSM_SRC_HSI);
    cmp_bit(o_ctl.tmr_double, 1'b0);
    rdc(8'h00, 32'h0000_5a81, 32'h0000_fff9);
    // Slow start-up shows the ready gating
    @(posedge i_clk_sys) i_slow <= 1'b1;
    wr(8'h24, 32'h0000_0001);
    repeat (5) tick;
    cmp_bit(o_ctl.gate[0], 1'b0);
    for (k = 0; k < 60 && o_ctl.gate[0] !== 1'b1; k++) tick;
    bound(k);
    @(posedge i_clk_sys) i_slow <= 1'b0;
    for (int r = 0; r < 6; r++)
    begin
      wr(rows[r].a, rows[r].d);
      rdc(rows[r].a, rows[r].e, rows[r].m);
    end
    cmp_bit(o_ctl.irq, 1'b1);
    rdc(8'h08, 32'h0000_0002, 32'h0000_0002);
    cmp_bit(o_ctl.lse_byp & o_ctl.lse_en, 1'b1);
    cmp_bit(o_ctl.tmr_double, 1'b1);
    wr(8'h08, 32'h003f_3f00);
    tick;
    cmp_bit(o_ctl.irq, 1'b0);
    wr(8'h20, 32'h0000_0205);
    rdc(8'h20, 32'h0000_0100, 32'h0000_0300);
    wr(8'h20, 32'h0001_0005);
    wr(8'h20, 32'h0000_0205);
    rdc(8'h20, 32'h0000_0200, 32'h0000_0300);
    wr(8'h00, 32'h0000_0048);
    rdc(8'h00, 32'h0000_0001, 32'h0000_0001);
    // PLL as system clock
    wr(8'h04, 32'h0010_0400);
    wr(8'h00, 32'h0100_0049);
    for (k = 0; k < 60 && o_ctl.gate[4] !== 1'b1; k++) tick;
    bound(k);
    tick;
    rdc(8'h08, 32'h0000_0010, 32'h0000_0010);
    cmp_bit(o_ctl.irq, 1'b1);
    wr(8'h04, 32'h0010_0402);
    for (k = 0; k < 60 && o_ctl.sys_src !== csm_pkg::CSM_SRC_PLL; k++) tick;
    bound(k);
    wr(8'h04, 32'h001c_0402);
    rdc(8'h04, 32'h0010_0000, 32'h003c_0000);
    wr(8'h00, 32'h0000_0049);
    rdc(8'h00, 32'h0100_0000, 32'h0100_0000);
    // Fast external crystal takes over, then the PLL is reconfigured
    wr(8'h00, 32'h010d_0049);
    for (k = 0; k < 60 && o_ctl.gate[3] !== 1'b1; k++) tick;
    bound(k);
    wr(8'h04, 32'h0010_0401);
    for (k = 0; k < 60 && o_ctl.sys_src !== csm_pkg::CSM_SRC_HSE; k++) tick;
    bound(k);
    wr(8'h00, 32'h000d_0049);
    // New setup only once the PLL ready level has left the synchronizer too
    for (k = 0; k < 60 && ready[4] !== 1'b0; k++) tick;
    bound(k);
    repeat (3) tick;
    wr(8'h04, 32'h001c_0401);
    wr(8'h00, 32'h010d_0049);
    for (k = 0; k < 60 && o_ctl.gate[4] !== 1'b1; k++) tick;
    bound(k);
    rdc(8'h04, 32'h001c_0000, 32'h003c_0000);
    // Crystal failure while it feeds the system clock
    @(posedge i_clk_sys) fail_cmd <= 1'b1;
    for (k = 0; k < 60 && o_ctl.nmi !== 1'b1; k++) tick;
    bound(k);
    tick;
    cmp_src(o_ctl.sys_src, csm_pkg::CSM_SRC_HSI);
    cmp_bit(o_ctl.hse_en, 1'b0);
    cmp_bit(o_ctl.hsi_en, 1'b1);
    rdc(8'h08, 32'h0000_0080, 32'h0000_0080);
    @(posedge i_clk_sys) fail_cmd <= 1'b0;
    repeat (4) tick;
    cmp_bit(o_ctl.nmi, 1'b1);
    wr(8'h08, 32'h0080_3f00);
    tick;
    cmp_bit(o_ctl.nmi, 1'b0);
    // Clock output pin, converter clock
    wr(8'h04, 32'h0310_0400);
    tick;
    cmp_bit(o_ctl.mco_sel == 3'h0, 1'b1);
    cmp_bit(o_ctl.adc_osc_route, 1'b0);
    @(posedge i_clk_sys) mco_af <= 1'b1;
    adc_sel <= 1'b1;
    repeat (3) tick;
    cmp_bit(o_ctl.mco_sel == 3'h3, 1'b1);
    cmp_bit(o_ctl.adc_osc_route, 1'b1);
    // Sleep with every bus peripheral clock off
    @(posedge i_clk_sys) lp <= csm_pkg::CSM_LP_SLEEP;
    clks_off <= 1'b1;
    repeat (3) tick;
    cmp_bit(o_ctl.cpu_clk_en | o_ctl.bridge_clk_en, 1'b0);
    @(posedge i_clk_sys) lp <= csm_pkg::CSM_LP_RUN;
    clks_off <= 1'b0;
    repeat (3) tick;
    cmp_bit(o_ctl.cpu_clk_en, 1'b1);
    // Watchdog lock on the slow internal oscillator
    @(posedge i_clk_sys) wdt <= 1'b1;
    wr(8'h24, 32'h0000_0000);
    tick;
    cmp_bit(o_ctl.lsi_en, 1'b1);
    rdc(8'h24, 32'h0000_0001, 32'h0000_0001);
    // Stop entry deferred by flash and bus activity, PLL feeding the system clock
    wr(8'h00, 32'h010d_0049);
    for (k = 0; k < 60 && o_ctl.gate[4] !== 1'b1; k++) tick;
    bound(k);
    wr(8'h04, 32'h0310_0402);
    for (k = 0; k < 60 && o_ctl.sys_src !== csm_pkg::CSM_SRC_PLL; k++) tick;
    bound(k);
    @(posedge i_clk_sys) flash_busy <= 1'b1;
    apb_busy <= 1'b1;
    lp <= csm_pkg::CSM_LP_STOP;
    repeat (6) tick;
    cmp_bit(o_ctl.deep_sleep, 1'b0);
    @(posedge i_clk_sys) flash_busy <= 1'b0;
    repeat (4) tick;
    cmp_bit(o_ctl.deep_sleep, 1'b0);
    @(posedge i_clk_sys) apb_busy <= 1'b0;
    for (k = 0; k < 60 && o_ctl.deep_sleep !== 1'b1; k++) tick;
    bound(k);
    tick;
    cmp_bit(o_ctl.hse_en | o_ctl.hsi_en | o_ctl.pll_en | o_ctl.adc_osc_en, 1'b0);
    cmp_bit(o_ctl.lsi_en, 1'b1);
    rdc(8'h00, 32'h0000_0000, 32'h0101_0000);
    // Wake-up by interrupt
    @(posedge i_clk_sys) lp <= csm_pkg::CSM_LP_RUN;
    wake <= 1'b1;
    @(posedge i_clk_sys) wake <= 1'b0;
    for (k = 0; k < 60 && o_ctl.deep_sleep !== 1'b0; k++) tick;
    bound(k);
    tick;
    cmp_src(o_ctl.sys_src, csm_pkg::CSM_SRC_HSI);
    cmp_bit(o_ctl.hsi_en, 1'b1);
    stop_test();
  end
  // Global limit against a hang
  initial
  begin
    #400000;
    bad("run limit");
    stop_test();
  end
endmodule
`default_nettype wire
